// ---- prhg_consts.vh ----
`ifndef PRHG_CONSTS_VH
`define PRHG_CONSTS_VH
// ----------------------------------------------------------------
// timing and test limits
// ----------------------------------------------------------------
`define PRHG_CLK_HZ 25000000
// power-up online test window in raw bits
`define PRHG_STARTUP_BITS 16'h0400
// continuous test window in raw bits
`define PRHG_WINDOW_BITS 16'h0100
// stuck bit run that counts as total failure
`define PRHG_RUN_LIMIT 8'h20
// monobit bounds for a 256 bit window (ones count)
`define PRHG_ONES_LO 16'h0060
`define PRHG_ONES_HI 16'h00a0
// injected-fault self test length in cycles
`define PRHG_SELFTEST_CYC 8'h40
`endif

// ---- prhg_health.v ----
`timescale 1ns/1ps
`include "prhg_consts.vh"
// ----------------------------------------------------------------
// raw-bit health checks: stuck run and windowed monobit count
// ----------------------------------------------------------------
module prhg_health #(
    parameter RUN_LIMIT = `PRHG_RUN_LIMIT,
    parameter WINDOW = `PRHG_WINDOW_BITS
) (
    input wire clk, // system clock
    input wire rst_n, // synchronous reset, active low
    input wire ce, // clock enable
    input wire restart, // clear counters, begin new window
    input wire bitValid, // raw bit strobe
    input wire rawBit, // raw bit
    output reg totalFail, // stuck run seen, sticky until restart
    output reg winDone, // one-cycle pulse at window end
    output reg winBad // window verdict, valid with winDone
);
    reg lastBit;
    reg [7:0] runLen;
    reg [15:0] bitCnt;
    reg [15:0] onesCnt;
    wire [15:0] onesNext = onesCnt + {15'h0000, rawBit};
    always @(posedge clk) begin
        if (!rst_n || (ce && restart)) begin
            lastBit <= 1'b0;
            runLen <= 8'h00;
            bitCnt <= 16'h0000;
            onesCnt <= 16'h0000;
            totalFail <= 1'b0;
            winDone <= 1'b0;
            winBad <= 1'b0;
        end else if (ce) begin
            winDone <= 1'b0;
            if (bitValid) begin
                lastBit <= rawBit;
                // runLen holds the length of the current run of equal bits, 0 after restart
                if (rawBit == lastBit && runLen != 8'h00) begin
                    if (runLen != 8'hff)
                        runLen <= runLen + 8'h01;
                end else begin
                    runLen <= 8'h01;
                end
                // a constant source is a total failure; flag on the bit that completes the run
                if (rawBit == lastBit && runLen != 8'h00 && runLen + 8'h01 >= RUN_LIMIT)
                    totalFail <= 1'b1;
                if (bitCnt == WINDOW - 1) begin
                    bitCnt <= 16'h0000;
                    onesCnt <= 16'h0000;
                    winDone <= 1'b1;
                    winBad <= (onesNext < `PRHG_ONES_LO) || (onesNext > `PRHG_ONES_HI);
                end else begin
                    bitCnt <= bitCnt + 16'h0001;
                    onesCnt <= onesNext;
                end
            end
        end
    end
endmodule

// ---- prhg_gate.v ----
`timescale 1ns/1ps
`include "prhg_consts.vh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module prhg_gate #(
    parameter STARTUP = `PRHG_STARTUP_BITS,
    parameter WINDOW = `PRHG_WINDOW_BITS
) (
    input wire clk, // system clock, 25 MHz
    input wire rst_n, // synchronous reset, active low
    input wire ce, // clock enable, freezes all state when low
    input wire rawValid, // raw bit strobe from entropy source
    input wire rawBit, // raw entropy bit
    input wire wide, // 1: 16 bit words, 0: 8 bit words
    input wire readReq, // reader takes the presented word
    input wire testReq, // pulse: run alarm path self test
    input wire restartReq, // pulse: restart generator after a failure
    output reg [15:0] rngData, // random word, upper byte zero in 8 bit mode
    output reg rngValid, // word available
    output reg blocked, // output blocked by failure or defect
    output reg ready, // power-up test passed, generator running
    output reg testBusy, // self test in progress
    output reg testPass // last self test saw the alarm fire
);
    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam ST_START = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_FAIL = 2'd2;
    localparam ST_TEST = 2'd3;

    reg [1:0] state;
    reg [15:0] startCnt;
    reg [15:0] shiftReg;
    reg [4:0] fill;
    reg [7:0] testCnt;
    reg sawAlarm;
    wire injecting = (state == ST_TEST);
    wire hBit = injecting ? 1'b1 : rawBit;
    wire hValid = injecting ? 1'b1 : rawValid;
    wire totalFail;
    wire winDone;
    wire winBad;
    reg hRestart;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // bits gathered per word for the selected width
    function [4:0] word_bits;
        input wideSel;
        begin
            word_bits = wideSel ? 5'd16 : 5'd8;
        end
    endfunction

    // word as presented; the upper byte stays zero in byte mode
    function [15:0] pack_word;
        input [15:0] bits;
        input wideSel;
        begin
            pack_word = wideSel ? bits : {8'h00, bits[7:0]};
        end
    endfunction

    // a stuck source or a failed window end blocks output
    function defect_seen;
        input stuckFail;
        input windowEnd;
        input windowBad;
        begin
            defect_seen = stuckFail || (windowEnd && windowBad);
        end
    endfunction

    // width is read live on every cycle, so a change also applies to the word being built
    wire [4:0] need = word_bits(wide);

    // ----------------------------------------------------------------
    // health monitor restart
    // ----------------------------------------------------------------
    // every restart also clears the sticky failure, so it is only issued where
    // the gate itself leaves the blocked or test state, or enters the self test
    always @* begin
        hRestart = 1'b0;
        case (state)
        ST_FAIL: hRestart = restartReq || testReq;
        ST_TEST: hRestart = (testCnt == 8'h00);
        default: hRestart = testReq;
        endcase
    end

    // ----------------------------------------------------------------
    // raw-bit health monitor
    // ----------------------------------------------------------------

    prhg_health #(
        .RUN_LIMIT(`PRHG_RUN_LIMIT),
        .WINDOW(WINDOW)
    ) uHealth (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .restart(hRestart),
        .bitValid(hValid),
        .rawBit(hBit),
        .totalFail(totalFail),
        .winDone(winDone),
        .winBad(winBad)
    );

    // ----------------------------------------------------------------
    // gating and word assembly
    // ----------------------------------------------------------------
    // bits collected into the assembly register are only released once a window end
    // confirms health; a failure flushes everything pending, but a word built from the
    // first bits of a stuck run can escape before the run limit is reached.
    always @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_START;
            startCnt <= 16'h0000;
            shiftReg <= 16'h0000;
            fill <= 5'd0;
            testCnt <= 8'h00;
            sawAlarm <= 1'b0;
            rngData <= 16'h0000;
            rngValid <= 1'b0;
            blocked <= 1'b0;
            ready <= 1'b0;
            testBusy <= 1'b0;
            testPass <= 1'b0;
        end else if (ce) begin
            if (rngValid && readReq)
                rngValid <= 1'b0;
            case (state)
            ST_START: begin
                // a self test may pre-empt the power-up test; it restarts it when done
                ready <= 1'b0;
                if (testReq) begin
                    state <= ST_TEST;
                    testCnt <= `PRHG_SELFTEST_CYC;
                    sawAlarm <= 1'b0;
                    testBusy <= 1'b1;
                end else if (defect_seen(totalFail, winDone, winBad)) begin
                    state <= ST_FAIL;
                    blocked <= 1'b1;
                end else if (rawValid) begin
                    if (startCnt == STARTUP - 1) begin
                        state <= ST_RUN;
                        ready <= 1'b1;
                        startCnt <= 16'h0000;
                    end else begin
                        startCnt <= startCnt + 16'h0001;
                    end
                end
            end
            ST_RUN: begin
                if (testReq) begin
                    state <= ST_TEST;
                    testCnt <= `PRHG_SELFTEST_CYC;
                    sawAlarm <= 1'b0;
                    testBusy <= 1'b1;
                    ready <= 1'b0;
                    rngValid <= 1'b0;
                    fill <= 5'd0;
                end else if (defect_seen(totalFail, winDone, winBad)) begin
                    state <= ST_FAIL;
                    blocked <= 1'b1;
                    ready <= 1'b0;
                    rngValid <= 1'b0;
                    fill <= 5'd0;
                end else begin
                    if (rawValid && fill < need) begin
                        shiftReg <= {shiftReg[14:0], rawBit};
                        fill <= fill + 5'd1;
                    end
                    // present only after a clean window end; the delay between a word's last bit
                    // capture and its release can be as short as one cycle, well below the run limit
                    // a new word waits until the previous one has been taken, so a read
                    // always ends the word it was aimed at
                    if (fill >= need && winDone && !rngValid) begin
                        rngData <= pack_word(shiftReg, wide);
                        rngValid <= 1'b1;
                        fill <= 5'd0;
                    end
                end
            end
            ST_FAIL: begin
                // the failure stays latched until a restart or a self test
                rngValid <= 1'b0;
                if (testReq) begin
                    state <= ST_TEST;
                    testCnt <= `PRHG_SELFTEST_CYC;
                    sawAlarm <= 1'b0;
                    testBusy <= 1'b1;
                end else if (restartReq) begin
                    state <= ST_START;
                    blocked <= 1'b0;
                    startCnt <= 16'h0000;
                end
            end
            ST_TEST: begin
                // a stuck source is injected; the alarm must fire in time
                if (totalFail)
                    sawAlarm <= 1'b1;
                if (testCnt == 8'h00) begin
                    state <= ST_START;
                    testBusy <= 1'b0;
                    testPass <= sawAlarm || totalFail;
                    blocked <= 1'b0;
                    startCnt <= 16'h0000;
                end else begin
                    testCnt <= testCnt - 8'h01;
                end
            end
            default: state <= ST_START;
            endcase
        end
    end
endmodule

// ---- prhg_asserts.sv ----
`timescale 1ns/1ps
// ----
// gating checks
// ----
module prhg_asserts (
    input wire clk, // clock
    input wire rst_n, // reset
    input wire ce, // enable
    input wire rawValid, // strobe
    input wire rawBit, // raw bit
    input wire wide, // width
    input wire readReq, // read
    input wire testReq, // test
    input wire restartReq, // restart
    input wire [15:0] rngData, // word
    input wire rngValid, // valid
    input wire blocked, // blocked
    input wire ready, // running
    input wire testBusy, // busy
    input wire testPass // result
);
    reg [5:0] run;
    reg last;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // equal-bit run length, saturating so a long stuck source never wraps
    always @(posedge clk) begin
        if (!rst_n) begin
            run <= 6'h00;
            last <= 1'b0;
        end else if (ce && rawValid) begin
            run <= (rawBit == last) ? run + {5'h00, run < 6'h20} : 6'h01;
            last <= rawBit;
        end
    end
    early_word_a: assert property (rngValid |-> ready && !testBusy)
        else $error("word before test passed");
    blocked_silent_a: assert property (blocked |-> !rngValid && !ready)
        else $error("word while blocked");
    byte_width_a: assert property (rngValid && !wide |-> rngData[15:8] == 8'h00)
        else $error("upper byte set in byte mode");
    stuck_block_a: assert property (ce && rawValid && !testBusy && rawBit == last
        && run == 6'h1f |-> ##[1:3] blocked)
        else $error("stuck source not blocked");
    read_clear_a: assert property (rngValid && readReq && ce |=> !rngValid)
        else $error("word kept after read");
    word_hold_a: assert property (rngValid && !readReq && ce
        |=> (rngValid && $stable(rngData)) || blocked || testBusy)
        else $error("word lost before read");
    test_start_a: assert property (ce && testReq && !testBusy |=> testBusy)
        else $error("self test not started");
    test_len_a: assert property ($rose(testBusy) |-> ##64 testBusy ##1 !testBusy && testPass)
        else $error("self test length or result wrong");
    restart_clr_a: assert property (ce && restartReq && blocked && !testReq |=> !blocked)
        else $error("restart left output blocked");
    cover property (rngValid && wide);
    cover property ($rose(blocked));
    cover property ($rose(testPass));
endmodule

// ---- prhg_reader.sv ----
`timescale 1ns/1ps
// ----
// processor side reading words
// ----
module prhg_reader (
    input wire clk, // clock
    input wire rngValid, // word available
    output reg readReq // take word
);
    initial readReq = 1'b0;
    // random stall of several cycles gives prompt and slow reads alike
    always @(posedge clk) begin
        readReq <= rngValid && ($urandom % 4 == 0);
    end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
// ----
// gate bench
// ----
module testbench;
    reg clk = 1'b0, rst_n = 1'b0, ce = 1'b1, rawValid = 1'b0, rawBit = 1'b0;
    reg wide = 1'b0, testReq = 1'b0, restartReq = 1'b0, stuck = 1'b0, seen = 1'b0;
    wire readReq, rngValid, blocked, ready, testBusy, testPass;
    wire [15:0] rngData;
    integer error_cnt = 0, n_compared = 0, words = 0, i, n;
    reg seenRd = 1'b0, seenWide = 1'b0;
    reg [15:0] mShift = 16'h0000;
    integer mFill = 0;
    prhg_gate #(.STARTUP(16'h0020), .WINDOW(16'h0100)) prhg_gate_i (.clk(clk), .rst_n(rst_n),
        .ce(ce), .rawValid(rawValid), .rawBit(rawBit), .wide(wide), .readReq(readReq),
        .testReq(testReq), .restartReq(restartReq), .rngData(rngData), .rngValid(rngValid),
        .blocked(blocked), .ready(ready), .testBusy(testBusy), .testPass(testPass));
    prhg_reader prhg_reader_i (.clk(clk), .rngValid(rngValid), .readReq(readReq));
    always #20 clk = ~clk;
    task automatic check(input [15:0] got, input [15:0] exp, input [39:0] what);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("Error %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // model: the first 8 or 16 raw bits taken while running form the next word
    always @(posedge clk) begin
        rawValid <= $urandom % 5 != 0;
        rawBit <= stuck || ($urandom % 2 == 1);
        seen <= rngValid;
        seenRd <= readReq;
        seenWide <= wide;
        if (rngValid && (!seen || seenRd)) begin
            words <= words + 1;
            check(rngData, seenWide ? mShift : {8'h00, mShift[7:0]}, "word");
            mFill = 0;
        end
        if (!rst_n || !ready) begin
            mFill = 0;
        end else if (rawValid && mFill < (wide ? 16 : 8)) begin
            mShift = {mShift[14:0], rawBit};
            mFill = mFill + 1;
        end
    end
    task wait_for(input integer which);
        for (i = 0; i < 4000 && (which ? blocked : ready) !== 1'b1; i = i + 1) @(posedge clk);
    endtask
    task fail_restart;
        begin
            stuck <= 1'b1;
            wait_for(1);
            check({14'h0000, blocked, ready}, 16'h0002, "fail");
            n = words;
            repeat (300) @(posedge clk);
            check(words[15:0], n[15:0], "held");
            stuck <= 1'b0;
            wide <= 1'b0;
            repeat (50) @(posedge clk);
            restartReq <= 1'b1;
            @(posedge clk) restartReq <= 1'b0;
            wait_for(0);
            check({15'h0000, ready}, 16'h0001, "rerun");
        end
    endtask
    task final_report;
        begin
            $display("compared %0d errors %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask
    initial begin
        void'($urandom(19));
        repeat (5) @(posedge clk);
        check({11'h000, rngValid, blocked, ready, testBusy, testPass}, 16'h0000, "reset");
        rst_n <= 1'b1;
        wait_for(0);
        check({15'h0000, ready}, 16'h0001, "ready");
        repeat (2000) @(posedge clk);
        check({15'h0000, words > 3}, 16'h0001, "bytes");
        wide <= 1'b1;
        n = words;
        repeat (2000) @(posedge clk);
        check({15'h0000, words > n + 3}, 16'h0001, "wide");
        fail_restart;
        testReq <= 1'b1;
        @(posedge clk) testReq <= 1'b0;
        repeat (70) @(posedge clk);
        check({14'h0000, testBusy, testPass}, 16'h0001, "test");
        fail_restart;
        final_report;
    end
    initial begin
        #800000;
        error_cnt = error_cnt + 1;
        final_report;
    end
endmodule
bind prhg_gate prhg_asserts prhg_asserts_i (.clk(clk), .rst_n(rst_n), .ce(ce),
    .rawValid(rawValid), .rawBit(rawBit), .wide(wide), .readReq(readReq), .testReq(testReq),
    .restartReq(restartReq), .rngData(rngData), .rngValid(rngValid), .blocked(blocked),
    .ready(ready), .testBusy(testBusy), .testPass(testPass));
